// ==== rtl/rkd_params.svh ====
/*
 * constants of the reservation key command decoder: register offsets,
 * command field positions, completion status codes and reset values.
 * assumes: included by its bare name, before the package and the top module.
 */
`ifndef RKD_PARAMS_SVH
`define RKD_PARAMS_SVH

// register byte offsets
`define RKD_OFS_DW0     8'h00
`define RKD_OFS_CDW10   8'h04
`define RKD_OFS_DATA    8'h08
`define RKD_OFS_CMD     8'h28
`define RKD_OFS_STATUS  8'h2C
`define RKD_OFS_CQE     8'h30
`define RKD_OFS_KEY_LO  8'h34
`define RKD_OFS_KEY_HI  8'h38
`define RKD_OFS_FETCH_LO 8'h3C
`define RKD_OFS_FETCH_HI 8'h40

// command word fields
`define RKD_ACT_MSB     2
`define RKD_ACT_LSB     0
`define RKD_IEK_BIT     3
`define RKD_PU_MSB      31
`define RKD_PU_LSB      30
`define RKD_FMT_BIT     15
`define RKD_GO_BIT      0
`define RKD_KIND_BIT    1

// status register bits
`define RKD_ST_PERSIST  0
`define RKD_ST_REGD     1
`define RKD_ST_HELD     2
`define RKD_ST_CQV      3

// completion status codes
`define RKD_SC_OK       8'h00
`define RKD_SC_INVALID  8'h02
`define RKD_SC_CONFLICT 8'h83

// reset values
`define RKD_PERSIST_RST 1'b0
`define RKD_WORD_RST    32'h0000_0000

`endif

// ==== rtl/rkd_pkg.sv ====
/*
 * types of the reservation key command decoder.
 * assumes: nothing beyond a SystemVerilog compiler.
 */
package rkd_pkg;
    // registration action encodings
    typedef enum logic [2:0] {
        RKD_ACT_REGISTER   = 3'b000,
        RKD_ACT_UNREGISTER = 3'b001,
        RKD_ACT_REPLACE    = 3'b010
    } rkd_reg_act_e;
    // release action encodings
    typedef enum logic [2:0] {
        RKD_REL_RELEASE = 3'b000,
        RKD_REL_CLEAR   = 3'b001
    } rkd_rel_act_e;
    // persistence update encodings
    typedef enum logic [1:0] {
        RKD_PU_KEEP  = 2'b00,
        RKD_PU_RSVD  = 2'b01,
        RKD_PU_CLEAR = 2'b10,
        RKD_PU_SET   = 2'b11
    } rkd_pu_e;
    typedef logic [63:0] rkd_key_t;
endpackage

// ==== rtl/rkd_top.sv ====
/*
 * reservation key command decoder: AHB-Lite register slave that runs
 * registration and release commands against the held key, the persist
 * state and the reservation, and posts one completion per command.
 * assumes: single clock, async active-high reset, word-only transfers.
 */
`include "rkd_params.svh"

module rkd_top
    import rkd_pkg::*;
#(
    parameter int NWORDS = 8
) (
    // clock and reset
    input  wire logic        SYS_CLK_IN,
    input  wire logic        RST_IN,
    // AHB-Lite slave
    input  wire logic        HSEL_IN,
    input  wire logic [31:0] HADDR_IN,
    input  wire logic [1:0]  HTRANS_IN,
    input  wire logic        HWRITE_IN,
    input  wire logic [2:0]  HSIZE_IN,
    input  wire logic [31:0] HWDATA_IN,
    input  wire logic        HREADY_IN,
    output logic      [31:0] HRDATA_OUT,
    output logic             HREADYOUT_OUT,
    output logic             HRESP_OUT,
    // reservation taken elsewhere
    input  wire logic        RESV_ACQUIRE_IN,
    // completion post
    output logic             CQ_POST_OUT,
    output logic      [7:0]  CQ_STATUS_OUT,
    output logic             CQ_KIND_OUT,
    // decoded data pointer and persist state
    output logic      [63:0] FETCH_ADDR_OUT,
    output logic      [63:0] FETCH_SECOND_OUT,
    output logic             FETCH_SGL_OUT,
    output logic             PERSIST_OUT
);
    // only eight data words are decoded, refuse anything else
    if (NWORDS != 8) begin : g_nwords_check
        $error("rkd_top: NWORDS must be 8");
    end

    logic [31:0] dw0_reg, cdw10_reg;
    logic [31:0] data_reg [NWORDS];
    logic        wr_ph_reg, rd_ph_reg;
    logic [7:0]  addr_reg;
    logic [31:0] rd_mux;
    logic        persist_reg, regd_reg, held_reg, cqv_reg;
    rkd_key_t    key_reg;
    logic        go, kind, iek, key_ok, bad, ok;
    logic [2:0]  act;
    logic [1:0]  pu;
    rkd_key_t    cur_key, new_key;
    logic [7:0]  sc;
    logic        wr_fire;

    // address phase capture
    always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            wr_ph_reg <= 1'b0;
            rd_ph_reg <= 1'b0;
            addr_reg  <= 8'h00;
        end else if (rd_ph_reg) begin
            rd_ph_reg <= 1'b0; // one wait state ends
        end else if (HREADY_IN) begin
            wr_ph_reg <= HSEL_IN & HTRANS_IN[1] & HWRITE_IN;
            rd_ph_reg <= HSEL_IN & HTRANS_IN[1] & ~HWRITE_IN;
            addr_reg  <= HADDR_IN[7:0];
        end
    end

    assign wr_fire       = wr_ph_reg;
    assign HREADYOUT_OUT = ~rd_ph_reg;
    assign HRESP_OUT     = 1'b0;

    // command words
    always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            dw0_reg   <= `RKD_WORD_RST;
            cdw10_reg <= `RKD_WORD_RST;
        end else if (wr_fire) begin
            if (addr_reg == `RKD_OFS_DW0) dw0_reg <= HWDATA_IN;
            if (addr_reg == `RKD_OFS_CDW10) cdw10_reg <= HWDATA_IN;
        end
    end

    // pointer words 0..3 and key structure words 4..7
    genvar gi;
    generate
        for (gi = 0; gi < NWORDS; gi++) begin : g_data
            always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
                if (RST_IN) begin
                    data_reg[gi] <= `RKD_WORD_RST;
                end else if (wr_fire && addr_reg == `RKD_OFS_DATA + 8'(4 * gi)) begin
                    data_reg[gi] <= HWDATA_IN;
                end
            end
        end
    endgenerate

    // command decode
    assign go    = wr_fire && addr_reg == `RKD_OFS_CMD && HWDATA_IN[`RKD_GO_BIT];
    assign kind  = HWDATA_IN[`RKD_KIND_BIT];
    assign act   = cdw10_reg[`RKD_ACT_MSB:`RKD_ACT_LSB];
    assign iek   = cdw10_reg[`RKD_IEK_BIT];
    assign pu    = cdw10_reg[`RKD_PU_MSB:`RKD_PU_LSB];
    assign cur_key = {data_reg[5], data_reg[4]};
    assign new_key = {data_reg[7], data_reg[6]};
    assign key_ok  = iek | (regd_reg & key_reg == cur_key);

    // validity and outcome of the command
    always_comb begin
        bad = 1'b0;
        ok  = key_ok;
        if (!kind) begin
            if (pu == RKD_PU_RSVD) bad = 1'b1;
            case (act)
                RKD_ACT_REGISTER:   ok = ~regd_reg | key_reg == new_key;
                RKD_ACT_UNREGISTER: ok = key_ok;
                RKD_ACT_REPLACE:    ok = key_ok;
                default:            bad = 1'b1;
            endcase
        end else begin
            case (act)
                RKD_REL_RELEASE: ok = key_ok;
                RKD_REL_CLEAR:   ok = key_ok;
                default:         bad = 1'b1;
            endcase
        end
        sc = bad ? `RKD_SC_INVALID : (ok ? `RKD_SC_OK : `RKD_SC_CONFLICT);
    end

    // key, registration and reservation state
    always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            key_reg  <= 64'h0;
            regd_reg <= 1'b0;
            held_reg <= 1'b0;
        end else if (go && !bad && ok) begin
            if (!kind) begin
                case (act)
                    RKD_ACT_UNREGISTER: begin
                        regd_reg <= 1'b0;
                        held_reg <= 1'b0;
                    end
                    default: begin
                        key_reg  <= new_key;
                        regd_reg <= 1'b1;
                    end
                endcase
            end else begin
                held_reg <= 1'b0;
                if (act == RKD_REL_CLEAR) regd_reg <= 1'b0;
            end
        end else if (RESV_ACQUIRE_IN && regd_reg) begin
            held_reg <= 1'b1;
        end
    end

    // persist-through-power-loss state
    always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            persist_reg <= `RKD_PERSIST_RST;
        end else if (go && !kind && !bad && ok) begin
            if (pu == RKD_PU_SET) persist_reg <= 1'b1;
            else if (pu == RKD_PU_CLEAR) persist_reg <= 1'b0;
        end
    end

    // completion post and sticky valid, set wins over clear
    always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            CQ_POST_OUT   <= 1'b0;
            CQ_STATUS_OUT <= 8'h00;
            CQ_KIND_OUT   <= 1'b0;
            cqv_reg       <= 1'b0;
        end else begin
            CQ_POST_OUT <= go;
            if (go) begin
                CQ_STATUS_OUT <= sc;
                CQ_KIND_OUT   <= kind;
                cqv_reg       <= 1'b1;
            end else if (wr_fire && addr_reg == `RKD_OFS_STATUS && HWDATA_IN[`RKD_ST_CQV]) begin
                cqv_reg <= 1'b0;
            end
        end
    end

    // pointer decode latched per command
    always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
        if (RST_IN) begin
            FETCH_ADDR_OUT   <= 64'h0;
            FETCH_SECOND_OUT <= 64'h0;
            FETCH_SGL_OUT    <= 1'b0;
        end else if (go) begin
            FETCH_SGL_OUT    <= dw0_reg[`RKD_FMT_BIT];
            FETCH_ADDR_OUT   <= {data_reg[1], data_reg[0]};
            FETCH_SECOND_OUT <= dw0_reg[`RKD_FMT_BIT] ? 64'h0 : {data_reg[3], data_reg[2]};
        end
    end

    assign PERSIST_OUT = persist_reg;

    // read mux, unmapped reads as zero
    always_comb begin
        rd_mux = 32'h0;
        case (addr_reg)
            `RKD_OFS_DW0:      rd_mux = dw0_reg;
            `RKD_OFS_CDW10:    rd_mux = cdw10_reg;
            `RKD_OFS_STATUS:   rd_mux = {28'h0, cqv_reg, held_reg, regd_reg, persist_reg};
            `RKD_OFS_CQE:      rd_mux = {23'h0, CQ_KIND_OUT, CQ_STATUS_OUT};
            `RKD_OFS_KEY_LO:   rd_mux = key_reg[31:0];
            `RKD_OFS_KEY_HI:   rd_mux = key_reg[63:32];
            `RKD_OFS_FETCH_LO: rd_mux = FETCH_ADDR_OUT[31:0];
            `RKD_OFS_FETCH_HI: rd_mux = FETCH_ADDR_OUT[63:32];
            default: begin
                if (addr_reg >= `RKD_OFS_DATA && addr_reg < `RKD_OFS_CMD)
                    rd_mux = data_reg[3'(addr_reg[4:2] - 3'd2)];
            end
        endcase
    end

    // read data loaded in the wait state
    always_ff @(posedge SYS_CLK_IN or posedge RST_IN) begin
        if (RST_IN) HRDATA_OUT <= 32'h0;
        else if (rd_ph_reg) HRDATA_OUT <= rd_mux;
    end

    default clocking cb @(posedge SYS_CLK_IN); endclocking
    default disable iff (RST_IN);

    sequence s_post;
        CQ_POST_OUT ##1 !CQ_POST_OUT;
    endsequence
    sequence s_rd_wait;
        !HREADYOUT_OUT ##1 HREADYOUT_OUT;
    endsequence

    property p_persist_set;
        go && !kind && !bad && ok && pu == RKD_PU_SET |=> PERSIST_OUT;
    endproperty
    a_persist_set: assert property (p_persist_set) else $error("persist not set");

    property p_persist_clr;
        go && !kind && !bad && ok && pu == RKD_PU_CLEAR |=> !PERSIST_OUT;
    endproperty
    a_persist_clr: assert property (p_persist_clr) else $error("persist not cleared");

    property p_persist_keep;
        go && pu == RKD_PU_KEEP |=> PERSIST_OUT == $past(PERSIST_OUT);
    endproperty
    a_persist_keep: assert property (p_persist_keep) else $error("persist changed");

    property p_iek;
        go && !kind && iek && act == RKD_ACT_REPLACE && pu != RKD_PU_RSVD |=> CQ_STATUS_OUT == `RKD_SC_OK;
    endproperty
    a_iek: assert property (p_iek) else $error("ignore-key replace failed");

    property p_rsvd;
        go && !kind && act > RKD_ACT_REPLACE |=> CQ_STATUS_OUT == `RKD_SC_INVALID && $stable(key_reg)
            && $stable(regd_reg) && $stable(PERSIST_OUT);
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved action not refused");

    property p_replace;
        go && !kind && !bad && ok && act == RKD_ACT_REPLACE |=> key_reg == $past(new_key) && regd_reg;
    endproperty
    a_replace: assert property (p_replace) else $error("key not replaced");

    property p_post;
        go ##1 !go |-> s_post;
    endproperty
    a_post: assert property (p_post) else $error("completion not posted once");

    property p_fetch;
        CQ_POST_OUT |-> FETCH_SGL_OUT == $past(dw0_reg[`RKD_FMT_BIT])
            && FETCH_SECOND_OUT == (FETCH_SGL_OUT ? 64'h0 : $past({data_reg[3], data_reg[2]}));
    endproperty
    a_fetch: assert property (p_fetch) else $error("pointer format wrong");

    property p_fetch_addr;
        CQ_POST_OUT |-> FETCH_ADDR_OUT == $past({data_reg[1], data_reg[0]});
    endproperty
    a_fetch_addr: assert property (p_fetch_addr) else $error("buffer address wrong");

    property p_release;
        go && kind && !bad && ok |=> !held_reg && CQ_KIND_OUT;
    endproperty
    a_release: assert property (p_release) else $error("release did not drop hold");

    property p_clear;
        go && kind && !bad && ok && act == RKD_REL_CLEAR |=> !regd_reg;
    endproperty
    a_clear: assert property (p_clear) else $error("clear kept registration");

    property p_unreg;
        go && !kind && !bad && ok && act == RKD_ACT_UNREGISTER |=> !regd_reg && !held_reg;
    endproperty
    a_unreg: assert property (p_unreg) else $error("unregister kept state");

    property p_post_only;
        !go |=> !CQ_POST_OUT;
    endproperty
    a_post_only: assert property (p_post_only) else $error("completion without command");

    property p_rd;
        HREADY_IN && HSEL_IN && HTRANS_IN[1] && !HWRITE_IN && HREADYOUT_OUT |=> s_rd_wait;
    endproperty
    a_rd: assert property (p_rd) else $error("read wait state wrong");
endmodule

// ==== dv/rkd_host.sv ====
/*
 * host model: AHB-Lite master that writes command words to the decoder
 * and reads its registers back.
 * assumes: one slave whose hreadyout is the bus hready; tasks entered
 * just after a rising clock edge.
 */
module rkd_host (
    // clock
    input  wire logic        clk_in,
    // bus answer
    input  wire logic        hready_in,
    input  wire logic [31:0] hrdata_in,
    // bus request
    output logic             hsel_out,
    output logic      [31:0] haddr_out,
    output logic      [1:0]  htrans_out,
    output logic             hwrite_out,
    output logic      [2:0]  hsize_out,
    output logic      [31:0] hwdata_out
);
    timeunit 1ns;
    timeprecision 1ps;

    // idle bus at time zero, word size only
    initial begin
        hsel_out   = 1'h0;
        haddr_out  = 32'h0;
        htrans_out = 2'h0;
        hwrite_out = 1'h0;
        hsize_out  = 3'h2;
        hwdata_out = 32'h0;
    end

    // wait for a rising edge at which hready is sampled high
    task automatic wait_rdy();
        do @(posedge clk_in); while (hready_in !== 1'h1);
    endtask

    // one single word transfer, each phase held until hready
    task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd, output logic [31:0] rd);
        hsel_out   <= 1'h1;
        haddr_out  <= a;
        hwrite_out <= wr;
        htrans_out <= 2'h2;
        wait_rdy(); // address phase taken
        htrans_out <= 2'h0;
        hwdata_out <= wd;
        wait_rdy(); // data phase ends, read data taken here
        rd = hrdata_in;
        hwdata_out <= ~wd; // select stays up with idle htrans between transfers
    endtask
endmodule

// ==== dv/tb.sv ====
/*
 * testbench of the reservation key command decoder: directed and random
 * commands through the host model, expectations from a bench model.
 * assumes: decoder and host model compiled before this file.
 */
`include "rkd_params.svh"
module tb;
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk = 1'h0;
    logic        rst = 1'h1;
    logic        hsel, hwrite, hready, hresp, acq = 1'h0;
    logic        post, kind, sgl, persist_o;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] haddr, hwdata, hrdata, s, c, seed = 32'd33627;
    logic [7:0]  st;
    logic [63:0] fa, fs, k1, k2, ck, key_m = 64'h0;
    logic        regd = 1'h0, held = 1'h0, persist_m = 1'h0;
    int          fail_count = 0, n_checks = 0, posts = 0;

    // clock and completion pulse counter
    always #2 clk = ~clk;
    always @(posedge clk) if (post === 1'h1) posts <= posts + 1;

    rkd_top i_rkd_top (.SYS_CLK_IN(clk), .RST_IN(rst), .HSEL_IN(hsel), .HADDR_IN(haddr), .HTRANS_IN(htrans),
        .HWRITE_IN(hwrite), .HSIZE_IN(hsize), .HWDATA_IN(hwdata), .HREADY_IN(hready), .HRDATA_OUT(hrdata),
        .HREADYOUT_OUT(hready), .HRESP_OUT(hresp), .RESV_ACQUIRE_IN(acq), .CQ_POST_OUT(post),
        .CQ_STATUS_OUT(st), .CQ_KIND_OUT(kind), .FETCH_ADDR_OUT(fa), .FETCH_SECOND_OUT(fs),
        .FETCH_SGL_OUT(sgl), .PERSIST_OUT(persist_o));
    rkd_host i_rkd_host (.clk_in(clk), .hready_in(hready), .hrdata_in(hrdata), .hsel_out(hsel),
        .haddr_out(haddr), .htrans_out(htrans), .hwrite_out(hwrite), .hsize_out(hsize), .hwdata_out(hwdata));

    // verdict and end of run
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
        n_checks++;
        if (g !== e) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        i_rkd_host.xfer(1'h1, {24'h0, a}, d, x);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        i_rkd_host.xfer(1'h0, {24'h0, a}, 32'h0, d);
        chk("hresp", 64'h0, hresp);
    endtask

    // expected completion status and state after one command
    function automatic logic [7:0] model(input logic k, input logic [31:0] c, input logic [63:0] ck, nk);
        logic m;
        m = c[3] | (regd & (ck == key_m));
        if (k) begin
            if (c[2:0] > 3'h1) return `RKD_SC_INVALID;
            if (!m) return `RKD_SC_CONFLICT;
            held = 1'h0;
            if (c[0]) regd = 1'h0;
            return `RKD_SC_OK;
        end
        if (c[2:0] > 3'h2 || c[31:30] == 2'h1) return 8'h02;
        if (c[2:0] == 3'h0 ? (regd && key_m != nk) : !m) return 8'h83;
        if (c[2:0] != 3'h1) key_m = nk;
        regd = c[2:0] != 3'h1;
        if (c[2:0] == 3'h1) held = 1'h0;
        if (c[31]) persist_m = c[30];
        return 8'h00;
    endfunction

    task automatic cmd(input logic k, input logic [31:0] c, input logic [63:0] ck, nk, input logic f);
        logic [31:0] w[8];
        logic [7:0]  e;
        int          p;
        for (int i = 0; i < 4; i++) w[i] = rnd();
        {w[5], w[4], w[7], w[6]} = {ck, nk};
        wr(`RKD_OFS_DW0, {16'h0, f, 15'h0});
        wr(`RKD_OFS_CDW10, c);
        for (int i = 0; i < 8; i++) wr(`RKD_OFS_DATA + 8'(4 * i), w[i]);
        e = model(k, c, ck, nk);
        p = posts;
        wr(`RKD_OFS_CMD, {30'h0, k, 1'h1});
        @(negedge clk);
        chk("post", 64'h1, post);
        chk("status", e, st);
        chk("kind", k, kind);
        chk("fetch", {w[1], w[0]}, fa);
        chk("second", f ? 64'h0 : {w[3], w[2]}, fs);
        chk("sgl", f, sgl);
        chk("persist", persist_m, persist_o);
        @(posedge clk);
        rd(`RKD_OFS_STATUS, s);
        chk("posts", p + 1, posts);
        chk("state", {1'h1, held, regd, persist_m}, s[3:0]);
        rd(`RKD_OFS_CQE, s);
        chk("entry", {k, e}, s[8:0]);
        rd(`RKD_OFS_FETCH_HI, s);
        chk("fetch hi", w[1], s);
    endtask

    // watchdog
    initial begin
        #100000;
        fail_count++;
        complete_run();
    end

    // main sequence
    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'h0;
        @(posedge clk);
        rd(`RKD_OFS_STATUS, s);
        chk("reset status", 64'h0, s);
        rd(8'h80, s);
        chk("unmapped", 64'h0, s);
        k1 = {rnd(), rnd()};
        k2 = ~k1;
        cmd(1'h0, 32'hC000_0000, 64'h0, k1, 1'h0);
        cmd(1'h0, 32'h0000_0002, k2, k2, 1'h1);
        cmd(1'h0, 32'h0000_000A, k2, k2, 1'h0);
        rd(`RKD_OFS_KEY_LO, s);
        chk("held key", k2[31:0], s);
        rd(`RKD_OFS_KEY_HI, s);
        chk("held key hi", k2[63:32], s);
        for (int a = 3; a < 8; a++) cmd(1'h0, 32'h8000_0000 | 32'(a), k2, k1, a[0]);
        cmd(1'h0, 32'h8000_0000, 64'h0, k2, 1'h1);
        cmd(1'h0, 32'h0000_0000, 64'h0, k2, 1'h0);
        acq <= 1'h1;
        @(posedge clk);
        acq <= 1'h0;
        held = regd;
        rd(`RKD_OFS_STATUS, s);
        chk("held", 64'h1, s[2]);
        cmd(1'h1, 32'h0, k1, 64'h0, 1'h0);
        cmd(1'h1, 32'h0, k2, 64'h0, 1'h1);
        cmd(1'h0, 32'h1, k2, 64'h0, 1'h1);
        cmd(1'h0, 32'h0, 64'h0, k1, 1'h0);
        cmd(1'h1, 32'h1, k1, 64'h0, 1'h0);
        cmd(1'h1, 32'h5, k1, 64'h0, 1'h0);
        wr(`RKD_OFS_STATUS, 32'h0000_0008);
        rd(`RKD_OFS_STATUS, s);
        chk("valid clear", 64'h0, s[3]);
        for (int i = 0; i < 10; i++) begin
            c = rnd() & 32'hC000_000F;
            c[2:0] = regd ? c[2:0] % 3'h3 : 3'h0;
            ck = (rnd() & 1) != 0 ? key_m : {rnd(), rnd()};
            cmd(1'h0, c, ck, {rnd(), rnd()}, rnd() & 1);
        end
        complete_run();
    end
endmodule
